// ---- shared/psmm_pkg.sv ----
// Constants, codes and carriers for the pulser-synchronised motion block
package psmm_pkg;
	localparam int CLK_PERIOD_NS = 100;
	localparam int DRF_TIME_NS = 26_000_000;
	localparam int DRF_CYCLES = DRF_TIME_NS / CLK_PERIOD_NS;
	localparam int FLT_W = 19;
	localparam int NIN = 7;
	localparam int IN_PA = 0;
	localparam int IN_PB = 1;
	localparam int IN_SEL = 2;
	localparam int IN_PLIM = 5;
	localparam int IN_MLIM = 6;

	localparam logic [11:0] OFS_MODE = 12'h000;
	localparam logic [11:0] OFS_CMD = 12'h004;
	localparam logic [11:0] OFS_ENV2 = 12'h008;
	localparam logic [11:0] OFS_ENV1 = 12'h00C;
	localparam logic [11:0] OFS_IRQ = 12'h010;
	localparam logic [11:0] OFS_EVENT = 12'h014;
	localparam logic [11:0] OFS_STATUS = 12'h018;
	localparam logic [11:0] OFS_ERROR = 12'h01C;
	localparam logic [11:0] OFS_MOVE = 12'h020;
	localparam logic [11:0] OFS_CNT1 = 12'h024;
	localparam logic [11:0] OFS_CNT2 = 12'h028;
	localparam logic [11:0] OFS_REMAIN = 12'h02C;
	localparam logic [11:0] OFS_SPEED = 12'h030;

	localparam int CMD_START = 0;
	localparam int CMD_STOP = 1;
	localparam int ENV2_PIM_LSB = 24;
	localparam int ENV2_PDIR = 26;
	localparam int ENV2_POFF = 31;
	localparam int ENV1_DRL = 25;
	localparam int ENV1_DRF = 27;
	localparam int IRQ_DR = 0;
	localparam int EV_PLUS = 17;
	localparam int EV_MINUS = 18;
	localparam int ST_CND_LSB = 0;
	localparam int ST_PLUS = 11;
	localparam int ST_MINUS = 12;
	localparam int ERR_OVF = 14;
	localparam logic [31:0] ENV2_MASK = 32'h8700_0000;
	localparam logic [31:0] ENV1_MASK = 32'h0A00_0000;

	localparam logic [31:0] ENV_RST = 32'h0000_0000;
	localparam logic [15:0] SPEED_RST = 16'h000A;
	localparam logic [2:0] FLT_RST = 3'h7;

	localparam logic [7:0] MOD_PCONT = 8'h01;
	localparam logic [7:0] MOD_SWCONT = 8'h02;
	localparam logic [7:0] MOD_PINC = 8'h51;
	localparam logic [7:0] MOD_PABS1 = 8'h52;
	localparam logic [7:0] MOD_PABS2 = 8'h53;
	localparam logic [7:0] MOD_PZR1 = 8'h54;
	localparam logic [7:0] MOD_PZR2 = 8'h55;
	localparam logic [7:0] MOD_PINT_LO = 8'h68;
	localparam logic [7:0] MOD_PINT_HI = 8'h6D;

	localparam logic [3:0] CND_IDLE = 4'h0;
	localparam logic [3:0] CND_SWWAIT = 4'h1;
	localparam logic [3:0] CND_RUN = 4'h2;
	localparam logic [3:0] CND_PWAIT = 4'h8;

	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;
	localparam logic signed [17:0] BUF_LIM = 18'sh0_FFFF;
	localparam logic signed [17:0] STEP_ONE = 18'sh0_0001;

	typedef enum logic [1:0] {ST_IDLE, ST_PWAIT, ST_RUN, ST_SWWAIT} psmm_fsm_t;
	typedef enum logic [1:0] {K_CONT, K_POS, K_INTERP, K_SWITCH} psmm_kind_t;

	typedef struct packed {
		logic pulser_phase_a;
		logic pulser_phase_b;
		logic axis_select_n;
		logic plus_dir_switch;
		logic minus_dir_switch;
		logic plus_limit;
		logic minus_limit;
	} psmm_pins_t;

	typedef struct packed {
		logic cmd_pulse_plus;
		logic cmd_pulse_minus;
		logic interp_start;
		logic interp_step;
	} psmm_out_t;

	typedef struct packed {
		logic awvalid;
		logic [31:0] awaddr;
		logic wvalid;
		logic [31:0] wdata;
		logic [3:0] wstrb;
		logic bready;
		logic arvalid;
		logic [31:0] araddr;
		logic rready;
	} psmm_axi_req_t;

	typedef struct packed {
		logic awready;
		logic wready;
		logic bvalid;
		logic [1:0] bresp;
		logic arready;
		logic rvalid;
		logic [31:0] rdata;
		logic [1:0] rresp;
	} psmm_axi_rsp_t;

	typedef struct packed {
		logic [NIN-1:0] sync1;
		logic [NIN-1:0] sync2;
		logic [1:0] prev_ab;
		logic [2:0][FLT_W-1:0] flt_cnt;
		logic [2:0] flt_lvl;
		logic [1:0] sw_prev;
		logic [31:0] env1;
		logic [31:0] env2;
		logic [7:0] mode;
		logic irq_en;
		logic [15:0] speed;
		logic ev_plus;
		logic ev_minus;
		logic ovf_err;
		logic [31:0] move;
		logic [31:0] cnt1;
		logic [31:0] cnt2;
		logic [31:0] rem;
		psmm_fsm_t fsm;
		psmm_kind_t kind;
		logic pos_dir;
		logic signed [17:0] pend;
		logic [15:0] tick;
		logic aw_full;
		logic [11:0] aw_addr;
		logic w_full;
		logic [31:0] w_data;
		logic [3:0] w_strb;
		psmm_out_t out;
		psmm_axi_rsp_t axi;
	} psmm_state_t;
endpackage

// ---- src/psmm_axis.sv ----
// One axis of pulser-synchronised motion modes with an AXI4-Lite slave
//
// Our own choices: the AXI4-Lite slave port and the register addresses.
`timescale 1ns/10ps
`default_nettype none
module psmm_axis #(
	parameter int DRF_CYCLES_P = psmm_pkg::DRF_CYCLES
) (
	input wire logic aclk, // System clock
	input wire logic aresetn, // Synchronous reset, active low
	input wire psmm_pkg::psmm_axi_req_t axi_req, // AXI4-Lite from master
	output var psmm_pkg::psmm_axi_rsp_t axi_rsp, // AXI4-Lite to master
	input wire psmm_pkg::psmm_pins_t pins, // Pulser, switch, limit pins
	output var psmm_pkg::psmm_out_t motion // Command pulses, interp start
);
	import psmm_pkg::*;

	psmm_state_t s;
	psmm_state_t n;
	logic start_w;
	logic stop_w;
	logic ovf_now;
	logic [1:0] ps;
	logic [1:0] sw_on;
	logic [1:0] sw_set;
	logic step_v;
	logic step_p;
	logic plim;
	logic mlim;

	function automatic logic [31:0] abs32(input logic [31:0] v);
		return v[31] ? (~v + 32'h0000_0001) : v;
	endfunction

	function automatic logic [31:0] bmask(input logic [3:0] st);
		logic [31:0] m;
		m = '0;
		for (int b = 0; b < 4; b++) begin
			m[b*8 +: 8] = {8{st[b]}};
		end
		return m;
	endfunction

	function automatic logic mapped(input logic [11:0] a);
		return a[1:0] == 2'h0 && a <= OFS_SPEED;
	endfunction

	// Live switch levels, polarity applied
	function automatic logic [1:0] sw_live(input psmm_state_t st);
		logic pol;
		pol = st.env1[ENV1_DRL];
		return {~(st.flt_lvl[2] ^ pol), ~(st.flt_lvl[1] ^ pol)};
	endfunction

	function automatic logic [31:0] rd_mux(input psmm_state_t st,
			input logic [11:0] a);
		logic [31:0] r;
		logic [1:0] sw;
		r = '0;
		sw = sw_live(st);
		case (a)
			OFS_MODE: r[7:0] = st.mode;
			OFS_ENV2: r = st.env2;
			OFS_ENV1: r = st.env1;
			OFS_IRQ: r[IRQ_DR] = st.irq_en;
			OFS_EVENT: begin
				r[EV_PLUS] = st.ev_plus;
				r[EV_MINUS] = st.ev_minus;
			end
			OFS_STATUS: begin
				case (st.fsm)
					ST_PWAIT: r[ST_CND_LSB +: 4] = CND_PWAIT;
					ST_RUN: r[ST_CND_LSB +: 4] = CND_RUN;
					ST_SWWAIT: r[ST_CND_LSB +: 4] = CND_SWWAIT;
					default: r[ST_CND_LSB +: 4] = CND_IDLE;
				endcase
				r[ST_PLUS] = sw[0];
				r[ST_MINUS] = sw[1];
			end
			OFS_ERROR: r[ERR_OVF] = st.ovf_err;
			OFS_MOVE: r = st.move;
			OFS_CNT1: r = st.cnt1;
			OFS_CNT2: r = st.cnt2;
			OFS_REMAIN: r = st.rem;
			OFS_SPEED: r[15:0] = st.speed;
			default: r = '0;
		endcase
		return r;
	endfunction

	// Returns {valid, plus} before the swap bit
	function automatic logic [1:0] pstep(input logic [1:0] fmt,
			input logic [1:0] pv, input logic [1:0] cu);
		logic [1:0] chg;
		logic [1:0] r;
		chg = pv ^ cu;
		r = 2'h0;
		case (fmt)
			2'h0: if (chg == 2'h2 && cu[1])
				r = {1'b1, ~cu[0]};
			2'h1: if (chg == 2'h2)
				r = {1'b1, cu[1] ^ cu[0]};
			2'h2: begin
				if (chg == 2'h2)
					r = {1'b1, cu[1] ^ cu[0]};
				else if (chg == 2'h1)
					r = {1'b1, ~(cu[1] ^ cu[0])};
			end
			default: begin
				if (chg[1] && cu[1] && !(chg[0] && cu[0]))
					r = 2'h3;
				else if (chg[0] && cu[0] && !(chg[1] && cu[1]))
					r = 2'h2;
			end
		endcase
		return r;
	endfunction

	always_comb begin
		logic [31:0] wd;
		logic [31:0] m;
		logic [31:0] tgt;
		logic [31:0] cur;
		logic [31:0] diff;
		logic [1:0] sw_clr;
		logic err_clr;
		logic emit;
		logic edir;
		logic blocked;
		logic signed [17:0] delta;
		logic signed [17:0] nb;
		n = s;
		start_w = 1'b0;
		stop_w = 1'b0;
		ovf_now = 1'b0;
		wd = '0;
		m = '0;
		tgt = '0;
		cur = '0;
		diff = '0;
		sw_clr = 2'h0;
		err_clr = 1'b0;
		emit = 1'b0;
		edir = 1'b0;
		blocked = 1'b0;
		delta = '0;
		nb = s.pend;
		n.out = '0;

		// Two-stage synchroniser on every pin
		n.sync1 = {pins.minus_limit, pins.plus_limit, pins.minus_dir_switch,
			pins.plus_dir_switch, pins.axis_select_n, pins.pulser_phase_b,
			pins.pulser_phase_a};
		n.sync2 = s.sync1;

		// Long filter for axis select and switches; a change must hold
		// for longer than the reject window before it is believed
		for (int i = 0; i < 3; i++) begin
			if (!s.env1[ENV1_DRF]) begin
				n.flt_lvl[i] = s.sync2[IN_SEL+i];
				n.flt_cnt[i] = '0;
			end else if (s.sync2[IN_SEL+i] == s.flt_lvl[i]) begin
				n.flt_cnt[i] = '0;
			end else if (s.flt_cnt[i] >= FLT_W'(DRF_CYCLES_P)) begin
				n.flt_lvl[i] = s.sync2[IN_SEL+i];
				n.flt_cnt[i] = '0;
			end else begin
				n.flt_cnt[i] = s.flt_cnt[i] + 1'b1;
			end
		end

		sw_on = sw_live(s);
		n.sw_prev = sw_on;
		sw_set = (sw_on ^ s.sw_prev) & {2{s.irq_en & ~s.flt_lvl[0]}};

		// AXI4-Lite write: address and data taken in either order
		if (s.axi.awready && axi_req.awvalid) begin
			n.aw_full = 1'b1;
			n.aw_addr = axi_req.awaddr[11:0];
			n.axi.awready = 1'b0;
		end
		if (s.axi.wready && axi_req.wvalid) begin
			n.w_full = 1'b1;
			n.w_data = axi_req.wdata;
			n.w_strb = axi_req.wstrb;
			n.axi.wready = 1'b0;
		end
		if (s.axi.bvalid && axi_req.bready) begin
			n.axi.bvalid = 1'b0;
		end
		if (s.aw_full && s.w_full && !s.axi.bvalid) begin
			n.aw_full = 1'b0;
			n.w_full = 1'b0;
			n.axi.awready = 1'b1;
			n.axi.wready = 1'b1;
			n.axi.bvalid = 1'b1;
			n.axi.bresp = mapped(s.aw_addr) ? RESP_OKAY : RESP_SLVERR;
			m = bmask(s.w_strb);
			wd = (rd_mux(s, s.aw_addr) & ~m) | (s.w_data & m);
			case (s.aw_addr)
				OFS_MODE: n.mode = wd[7:0];
				OFS_CMD: begin
					start_w = s.w_data[CMD_START] & m[CMD_START];
					stop_w = s.w_data[CMD_STOP] & m[CMD_STOP];
				end
				OFS_ENV2: n.env2 = wd & ENV2_MASK;
				OFS_ENV1: n.env1 = wd & ENV1_MASK;
				OFS_IRQ: n.irq_en = wd[IRQ_DR];
				OFS_EVENT: sw_clr = {s.w_data[EV_MINUS] & m[EV_MINUS],
					s.w_data[EV_PLUS] & m[EV_PLUS]};
				OFS_ERROR: err_clr = s.w_data[ERR_OVF] & m[ERR_OVF];
				OFS_MOVE: n.move = wd;
				OFS_CNT1: n.cnt1 = wd;
				OFS_CNT2: n.cnt2 = wd;
				OFS_SPEED: n.speed = wd[15:0];
				default: n.mode = s.mode;
			endcase
		end

		// AXI4-Lite read: data one cycle after the address is taken
		if (s.axi.rvalid && axi_req.rready) begin
			n.axi.rvalid = 1'b0;
			n.axi.arready = 1'b1;
		end
		if (s.axi.arready && axi_req.arvalid) begin
			n.axi.arready = 1'b0;
			n.axi.rvalid = 1'b1;
			n.axi.rdata = rd_mux(s, axi_req.araddr[11:0]);
			n.axi.rresp = mapped(axi_req.araddr[11:0]) ? RESP_OKAY
				: RESP_SLVERR;
		end

		// Set wins over a clear in the same cycle
		n.ev_plus = (s.ev_plus & ~sw_clr[0]) | sw_set[0];
		n.ev_minus = (s.ev_minus & ~sw_clr[1]) | sw_set[1];
		n.ovf_err = s.ovf_err & ~err_clr;

		ps = pstep(s.env2[ENV2_PIM_LSB +: 2], s.prev_ab,
			{s.sync2[IN_PA], s.sync2[IN_PB]});
		n.prev_ab = {s.sync2[IN_PA], s.sync2[IN_PB]};
		step_v = ps[1] & ~s.flt_lvl[0] & ~s.env2[ENV2_POFF];
		step_p = ps[0] ^ s.env2[ENV2_PDIR];
		plim = s.sync2[IN_PLIM];
		mlim = s.sync2[IN_MLIM];

		case (s.fsm)
			ST_IDLE: if (start_w && !stop_w) begin
				n.pend = '0;
				n.tick = '0;
				n.kind = K_POS;
				tgt = s.move;
				cur = s.cnt1;
				case (s.mode)
					MOD_PCONT: begin
						n.kind = K_CONT;
						n.fsm = ST_PWAIT;
					end
					MOD_SWCONT: begin
						n.kind = K_SWITCH;
						n.fsm = ST_SWWAIT;
					end
					MOD_PINC, MOD_PABS1, MOD_PABS2, MOD_PZR1,
					MOD_PZR2: begin
						if (s.mode == MOD_PINC)
							cur = '0;
						else if (s.mode == MOD_PABS2 || s.mode == MOD_PZR2)
							cur = s.cnt2;
						if (s.mode == MOD_PZR1 || s.mode == MOD_PZR2)
							tgt = '0;
						diff = tgt - cur;
						n.rem = abs32(diff);
						n.pos_dir = ~diff[31];
						if (diff != '0)
							n.fsm = ST_PWAIT;
					end
					default: if (s.mode >= MOD_PINT_LO &&
							s.mode <= MOD_PINT_HI) begin
						n.kind = K_INTERP;
						n.fsm = ST_PWAIT;
					end
				endcase
			end
			ST_PWAIT, ST_RUN: begin
				edir = (s.kind == K_POS) ? s.pos_dir : ~s.pend[17];
				blocked = edir ? plim : mlim;
				if (s.pend != '0 && s.tick == '0) begin
					// Steps toward a limit are dropped, not kept, so the
					// axis never lurches once the limit releases
					if (blocked)
						nb = '0;
					else
						emit = 1'b1;
				end
				if (emit)
					nb = s.pend[17] ? s.pend + STEP_ONE : s.pend - STEP_ONE;
				if (step_v) begin
					n.fsm = ST_RUN;
					if (s.kind == K_INTERP) begin
						n.out.interp_step = 1'b1;
						n.out.interp_start = s.fsm == ST_PWAIT;
					end else if (s.kind == K_POS || step_p) begin
						delta = STEP_ONE;
					end else begin
						delta = -STEP_ONE;
					end
				end
				nb = nb + delta;
				n.pend = nb;
				if (nb > BUF_LIM || nb < -BUF_LIM) begin
					ovf_now = 1'b1;
					n.ovf_err = 1'b1;
					n.fsm = ST_IDLE;
					n.pend = '0;
				end
			end
			ST_SWWAIT: begin
				edir = sw_on[0];
				blocked = edir ? plim : mlim;
				emit = (sw_on != 2'h0) && s.tick == '0 && !blocked;
			end
			default: n.fsm = ST_IDLE;
		endcase

		if (emit) begin
			n.out.cmd_pulse_plus = edir;
			n.out.cmd_pulse_minus = ~edir;
			n.tick = s.speed;
			n.cnt1 = edir ? n.cnt1 + 32'h0000_0001 : n.cnt1 - 32'h0000_0001;
			n.cnt2 = edir ? n.cnt2 + 32'h0000_0001 : n.cnt2 - 32'h0000_0001;
			if (s.kind == K_POS && s.fsm != ST_SWWAIT) begin
				n.rem = s.rem - 32'h0000_0001;
				if (s.rem == 32'h0000_0001) begin
					n.fsm = ST_IDLE;
					n.pend = '0;
				end
			end
		end else if (s.tick != '0) begin
			n.tick = s.tick - 16'h0001;
		end

		if (stop_w && s.fsm != ST_IDLE) begin
			n.fsm = ST_IDLE;
			n.pend = '0;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s <= '0;
			s.flt_lvl <= FLT_RST;
			s.env1 <= ENV_RST;
			s.env2 <= ENV_RST;
			s.speed <= SPEED_RST;
			s.axi.awready <= 1'b1;
			s.axi.wready <= 1'b1;
			s.axi.arready <= 1'b1;
		end else begin
			s <= n;
		end
	end

	assign axi_rsp = s.axi;
	assign motion = s.out;

	default clocking cb @(posedge aclk);
	endclocking
	default disable iff (!aresetn);

	a_wait_no_pulse: assert property (
		s.fsm == ST_PWAIT && s.pend == '0
		|=> !s.out.cmd_pulse_plus && !s.out.cmd_pulse_minus)
		else $error("pulse emitted with no pulser input");
	a_plus_limit_hold: assert property (
		s.fsm != ST_IDLE && s.kind == K_CONT && s.sync2[IN_PLIM]
		&& !s.pend[17] |=> !s.out.cmd_pulse_plus)
		else $error("plus pulse with plus limit on");
	a_minus_limit_hold: assert property (
		s.fsm != ST_IDLE && s.kind == K_CONT && s.sync2[IN_MLIM]
		&& s.pend[17] |=> !s.out.cmd_pulse_minus)
		else $error("minus pulse with minus limit on");
	a_cont_stays_on: assert property (
		s.fsm == ST_RUN && s.kind == K_CONT && !stop_w && !ovf_now
		|=> s.fsm == ST_RUN)
		else $error("continuous mode ended without stop");
	a_zero_move_done: assert property (
		start_w && !stop_w && s.fsm == ST_IDLE && s.mode == MOD_PINC
		&& s.move == '0 |=> s.fsm == ST_IDLE ##1
		(!s.out.cmd_pulse_plus && !s.out.cmd_pulse_minus))
		else $error("zero move did not complete at once");
	a_pos_last_pulse: assert property (
		(s.out.cmd_pulse_plus || s.out.cmd_pulse_minus)
		&& $past(s.kind == K_POS && s.fsm == ST_RUN && s.rem == 32'h1)
		|-> s.fsm == ST_IDLE && s.rem == '0)
		else $error("positioning did not end at zero");
	a_stop_completes: assert property (
		stop_w && s.fsm != ST_IDLE |=> s.fsm == ST_IDLE [*2])
		else $error("stop did not complete the mode");
	a_abs_load: assert property (
		start_w && !stop_w && s.fsm == ST_IDLE && s.mode == MOD_PABS1
		|=> s.rem == abs32($past(s.move) - $past(s.cnt1)))
		else $error("absolute load wrong");
	a_event_blocked: assert property (
		$rose(s.ev_plus) || $rose(s.ev_minus) |-> $past(!s.flt_lvl[0]))
		else $error("switch event with axis select high");
	a_pulser_gate: assert property (
		s.fsm == ST_PWAIT && (s.flt_lvl[0] || s.env2[ENV2_POFF])
		&& !stop_w |=> s.fsm == ST_PWAIT)
		else $error("pulser accepted while disabled");
	a_overflow_stop: assert property (
		ovf_now |=> s.ovf_err && s.fsm == ST_IDLE && s.pend == '0)
		else $error("overflow did not stop with error");
endmodule
`default_nettype wire

// ---- verif/psmm_far.sv ----
// Far-side model: hand pulser, switches, limits and a pulse-counting driver
`timescale 1ns/10ps
`default_nettype none
module psmm_far (
	input wire logic aclk, // System clock
	input wire psmm_pkg::psmm_out_t motion, // Pulses from the block
	output var psmm_pkg::psmm_pins_t pins // Pulser, switch, limit pins
);
	import psmm_pkg::*;
	int n_plus = 0;
	int n_minus = 0;
	int n_istart = 0;
	int n_istep = 0;
	initial begin
		pins = '0;
		pins.plus_dir_switch = 1'b1;
		pins.minus_dir_switch = 1'b1;
	end
	// Motor driver side only counts what it is handed
	always @(posedge aclk) begin
		if (motion.cmd_pulse_plus === 1'b1)
			n_plus++;
		if (motion.cmd_pulse_minus === 1'b1)
			n_minus++;
		if (motion.interp_start === 1'b1)
			n_istart++;
		if (motion.interp_step === 1'b1)
			n_istep++;
	end
	// Six cycles a phase, slow enough to outlast the input sync
	task ph(input logic a, input logic b);
		pins.pulser_phase_a <= a;
		pins.pulser_phase_b <= b;
		repeat (6) @(posedge aclk);
	endtask
	task step(input logic [1:0] fmt, input logic up);
		if (fmt == 2'h3) begin
			if (up)
				ph(1'b1, 1'b0);
			else
				ph(1'b0, 1'b1);
			ph(1'b0, 1'b0);
		end else if (up) begin
			ph(1'b1, 1'b0);
			ph(1'b1, 1'b1);
			ph(1'b0, 1'b1);
			ph(1'b0, 1'b0);
		end else begin
			ph(1'b0, 1'b1);
			ph(1'b1, 1'b1);
			ph(1'b1, 1'b0);
			ph(1'b0, 1'b0);
		end
	endtask
	task lvl(input logic [4:0] v);
		pins.axis_select_n <= v[4];
		pins.plus_dir_switch <= v[3];
		pins.minus_dir_switch <= v[2];
		pins.plus_limit <= v[1];
		pins.minus_limit <= v[0];
		@(posedge aclk);
	endtask
endmodule
`default_nettype wire

// ---- verif/tb_top.sv ----
// Self-checking bench for the pulser-synchronised motion axis
`timescale 1ns/10ps
`default_nettype none
module tb_top;
	import psmm_pkg::*;
	localparam int DRF_SIM = 8;
	logic aclk = 1'b0;
	logic aresetn = 1'b0;
	psmm_axi_req_t req = '0;
	psmm_axi_rsp_t rsp;
	psmm_pins_t pins;
	psmm_out_t motion;
	logic [31:0] rdat;
	logic [1:0] rrsp;
	logic [1:0] brsp;
	int n_mismatch = 0;
	int comparisons = 0;
	int cycles = 0;
	int bp;
	int bm;
	int k;
	logic [7:0] md [7] = '{8'h51, 8'h51, 8'h51, 8'h52, 8'h53, 8'h54, 8'h55};
	logic [11:0] ca [7] = '{12'h024, 12'h024, 12'h024, 12'h024, 12'h028,
		12'h024, 12'h028};
	logic [31:0] cv [7] = '{0, 0, 0, 5, 7, 3, 2};
	logic [31:0] mv [7] = '{3, 32'hFFFF_FFFE, 0, 3, 7, 9, 9};
	int ep [7] = '{3, 0, 0, 0, 0, 0, 0};
	int em [7] = '{0, 2, 0, 2, 0, 3, 2};
	always #50 aclk = ~aclk;
	psmm_axis #(.DRF_CYCLES_P(DRF_SIM)) psmm_axis_inst (.aclk(aclk),
		.aresetn(aresetn), .axi_req(req), .axi_rsp(rsp), .pins(pins),
		.motion(motion));
	psmm_far psmm_far_inst (.aclk(aclk), .motion(motion), .pins(pins));
	always @(posedge aclk) begin
		cycles++;
		if (cycles == 12000) begin
			n_mismatch++;
			$display("unexpected at %0t: run took too long", $time);
			wrap_up();
		end
	end
	task wrap_up();
		$display("comparisons %0d, mismatches %0d", comparisons, n_mismatch);
		if (n_mismatch == 0 && comparisons > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask
	task cmp_d(input logic [31:0] got, input logic [31:0] exp);
		comparisons++;
		if (got !== exp) begin
			n_mismatch++;
			$display("unexpected at %0t: got %h, want %h", $time, got, exp);
		end
	endtask
	task cmp_r(input logic [1:0] got, input logic [1:0] exp);
		comparisons++;
		if (got !== exp) begin
			n_mismatch++;
			$display("unexpected at %0t: resp %h, want %h", $time, got, exp);
		end
	endtask
	// Response ready stays up once raised, so no release race
	task wr(input logic [11:0] a, input logic [31:0] d);
		wrs(a, d, 4'hF);
	endtask
	task wrs(input logic [11:0] a, input logic [31:0] d,
			input logic [3:0] st);
		req.awaddr <= {20'h0_0000, a};
		req.wdata <= d;
		req.wstrb <= st;
		req.awvalid <= 1'b1;
		req.wvalid <= 1'b1;
		req.bready <= 1'b1;
		do begin
			@(posedge aclk);
			if (req.awvalid && rsp.awready === 1'b1)
				req.awvalid <= 1'b0;
			if (req.wvalid && rsp.wready === 1'b1)
				req.wvalid <= 1'b0;
		end while (rsp.bvalid !== 1'b1);
		brsp = rsp.bresp;
	endtask
	task rd(input logic [11:0] a);
		req.araddr <= {20'h0_0000, a};
		req.arvalid <= 1'b1;
		req.rready <= 1'b1;
		do begin
			@(posedge aclk);
			if (req.arvalid && rsp.arready === 1'b1)
				req.arvalid <= 1'b0;
		end while (rsp.rvalid !== 1'b1);
		rdat = rsp.rdata;
		rrsp = rsp.rresp;
	endtask
	task chk(input logic [11:0] a, input logic [31:0] m, input logic [31:0] e);
		rd(a);
		cmp_d(rdat & m, e);
	endtask
	task mark();
		bp = psmm_far_inst.n_plus;
		bm = psmm_far_inst.n_minus;
	endtask
	task cnt(input int p, input int m);
		repeat (30) @(posedge aclk);
		cmp_d(psmm_far_inst.n_plus - bp, p);
		cmp_d(psmm_far_inst.n_minus - bm, m);
	endtask
	task go(input logic [7:0] m);
		wr(OFS_MODE, {24'h00_0000, m});
		mark();
		wr(OFS_CMD, 32'h0000_0001);
	endtask
	initial begin
		repeat (4) @(posedge aclk);
		aresetn <= 1'b1;
		@(posedge aclk);
		chk(OFS_STATUS, 32'h0000_000F, 32'h0000_0000);
		rd(12'h034);
		cmp_r(rrsp, RESP_SLVERR);
		cmp_d(rdat, 32'h0000_0000);
		wr(12'h036, 32'h0000_0001);
		cmp_r(brsp, RESP_SLVERR);
		wr(OFS_SPEED, 32'h0000_0001);
		cmp_r(brsp, RESP_OKAY);
		// Byte strobes: only lanes 0 and 2 may change
		wr(OFS_MOVE, 32'h1234_5678);
		wrs(OFS_MOVE, 32'hAAAA_BBBB, 4'h5);
		chk(OFS_MOVE, 32'hFFFF_FFFF, 32'h12AA_56BB);
		$display("test bus done");
		go(MOD_PCONT);
		chk(OFS_STATUS, 32'h0000_000F, {28'h000_0000, CND_PWAIT});
		cnt(0, 0);
		for (int f = 0; f < 4; f++) begin
			for (int s = 0; s < 2; s++) begin
				wr(OFS_ENV2, (f << 24) | (s << 26));
				k = (f == 1) ? 2 : (f == 2) ? 4 : 1;
				mark();
				psmm_far_inst.step(f[1:0], 1'b1);
				cnt(s ? 0 : k, s ? k : 0);
				mark();
				psmm_far_inst.step(f[1:0], 1'b0);
				cnt(s ? k : 0, s ? 0 : k);
			end
		end
		wr(OFS_ENV2, 32'h0000_0000);
		psmm_far_inst.lvl(5'b01110);
		mark();
		psmm_far_inst.step(2'h0, 1'b1);
		cnt(0, 0);
		mark();
		psmm_far_inst.step(2'h0, 1'b0);
		cnt(0, 1);
		rd(OFS_STATUS);
		cmp_d({31'h0, rdat[3:0] == CND_IDLE}, 32'h0000_0000);
		psmm_far_inst.lvl(5'b01100);
		wr(OFS_ENV2, 32'h8000_0000);
		mark();
		psmm_far_inst.step(2'h0, 1'b1);
		cnt(0, 0);
		// Restart so the gate is also held against the waiting state
		wr(OFS_CMD, 32'h0000_0002);
		go(MOD_PCONT);
		psmm_far_inst.step(2'h0, 1'b1);
		cnt(0, 0);
		wr(OFS_ENV2, 32'h0000_0000);
		psmm_far_inst.lvl(5'b11100);
		mark();
		psmm_far_inst.step(2'h0, 1'b1);
		cnt(0, 0);
		chk(OFS_STATUS, 32'h0000_000F, {28'h000_0000, CND_PWAIT});
		psmm_far_inst.lvl(5'b01100);
		wr(OFS_CMD, 32'h0000_0002);
		chk(OFS_STATUS, 32'h0000_000F, 32'h0000_0000);
		$display("test continuous done");
		// Minus steps throughout: direction must come from the move only
		for (int i = 0; i < 7; i++) begin
			wr(ca[i], cv[i]);
			wr(OFS_MOVE, mv[i]);
			go(md[i]);
			repeat (4) psmm_far_inst.step(2'h0, 1'b0);
			cnt(ep[i], em[i]);
			chk(OFS_STATUS, 32'h0000_000F, 32'h0000_0000);
		end
		chk(OFS_CNT2, 32'hFFFF_FFFF, 32'h0000_0000);
		wr(OFS_MOVE, 32'h0000_0064);
		go(MOD_PINC);
		psmm_far_inst.step(2'h0, 1'b1);
		wr(OFS_CMD, 32'h0000_0002);
		chk(OFS_STATUS, 32'h0000_000F, 32'h0000_0000);
		mark();
		psmm_far_inst.step(2'h0, 1'b1);
		cnt(0, 0);
		go(MOD_PINT_LO);
		chk(OFS_STATUS, 32'h0000_000F, {28'h000_0000, CND_PWAIT});
		psmm_far_inst.step(2'h0, 1'b1);
		cmp_d(psmm_far_inst.n_istart, 32'h0000_0001);
		cmp_d(psmm_far_inst.n_istep, 32'h0000_0001);
		wr(OFS_CMD, 32'h0000_0002);
		$display("test positioning done");
		wr(OFS_IRQ, 32'h0000_0001);
		go(MOD_SWCONT);
		chk(OFS_STATUS, 32'h0000_000F, {28'h000_0000, CND_SWWAIT});
		psmm_far_inst.lvl(5'b00100);
		repeat (10) @(posedge aclk);
		chk(OFS_STATUS, 32'h0000_1800, 32'h0000_0800);
		chk(OFS_EVENT, 32'h0006_0000, 32'h0002_0000);
		cmp_d(psmm_far_inst.n_minus - bm, 32'h0000_0000);
		cmp_d({31'h0, psmm_far_inst.n_plus > bp}, 32'h0000_0001);
		psmm_far_inst.lvl(5'b01100);
		wr(OFS_CMD, 32'h0000_0002);
		wr(OFS_ENV1, 32'h0200_0000);
		psmm_far_inst.lvl(5'b11100);
		repeat (10) @(posedge aclk);
		wr(OFS_EVENT, 32'h0006_0000);
		psmm_far_inst.lvl(5'b11000);
		repeat (10) @(posedge aclk);
		chk(OFS_EVENT, 32'h0006_0000, 32'h0000_0000);
		chk(OFS_STATUS, 32'h0000_1800, 32'h0000_0800);
		psmm_far_inst.lvl(5'b01100);
		// Four-cycle glitch: seen unfiltered, lost under the long window
		for (int f = 0; f < 2; f++) begin
			wr(OFS_ENV1, f ? 32'h0A00_0000 : 32'h0200_0000);
			repeat (20) @(posedge aclk);
			wr(OFS_EVENT, 32'h0006_0000);
			psmm_far_inst.lvl(5'b01000);
			repeat (3) @(posedge aclk);
			psmm_far_inst.lvl(5'b01100);
			repeat (20) @(posedge aclk);
			chk(OFS_EVENT, 32'h0006_0000, f ? 0 : 32'h0004_0000);
		end
		$display("test switch done");
		wrap_up();
	end
endmodule
`default_nettype wire
